// ### common/bsp_pkg.sv
// Constants, types and carriers shared by the basic serial port
package bsp_pkg;

   // Register addresses on the special function register port
   localparam logic [7:0] BSP_ADDR_DATA = 8'h9B;
   localparam logic [7:0] BSP_ADDR_SCTL = 8'h9A;
   localparam logic [7:0] BSP_ADDR_TCTL = 8'h9D;
   localparam logic [7:0] BSP_ADDR_CSEL = 8'hF2;
   localparam logic [7:0] BSP_ADDR_PDN = 8'hF1;

   // serial_control_reg fields
   localparam int BSP_SC_CPHA = 0;
   localparam int BSP_SC_CPOL = 1;
   localparam int BSP_SC_LSBF = 2;
   localparam int BSP_SC_SSEN = 3;
   localparam int BSP_SC_CNT_LO = 4;
   localparam logic [3:0] BSP_SC_RST = 4'h0;

   // two_wire_control_reg fields
   localparam int BSP_TC_I2C = 0;
   localparam int BSP_TC_COUNT_LENGTH_SELECT = 1;
   localparam int BSP_TC_STRETCH = 2;
   localparam int BSP_TC_SSIF = 7;
   localparam logic [2:0] BSP_TC_RST = 3'h0;

   // peripheral_power_down_reg: bit of this port, powered down at reset
   localparam int BSP_PD_SPI = 1;
   localparam logic BSP_PDN_RST = 1'b1;

   // Bit counter values
   localparam logic [3:0] BSP_CNT_ZERO = 4'h0;
   localparam logic [3:0] BSP_CNT_ONE = 4'h1;
   localparam logic [3:0] BSP_CNT_BYTE = 4'h8;

   // Serial clock sources held in clock_source_select
   typedef enum logic [2:0]
   {
      BSP_CS_EXT = 3'h0,
      BSP_CS_SW = 3'h1,
      BSP_CS_WR_PULSE = 3'h2,
      BSP_CS_WR_TOG = 3'h3,
      BSP_CS_T0_PULSE = 3'h4,
      BSP_CS_T0_TOG = 3'h5,
      BSP_CS_T1_PULSE = 3'h6,
      BSP_CS_T1_TOG = 3'h7
   } bsp_clk_src_t;

   // One register access from the processor
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bsp_sfr_req_t;

   // Pin levels arriving from outside
   typedef struct packed
   {
      logic ss_n;
      logic din;
      logic sck;
   } bsp_pin_in_t;

   // Pin drive towards the pad ring
   typedef struct packed
   {
      logic sck_out;
      logic sck_oe;
      logic dout_out;
      logic dout_oe;
   } bsp_pin_out_t;

endpackage

// ### hw/bsp_serial_port.sv
// Basic SPI / software-assisted I2C serial port with its registers
`timescale 1ns/1ns

module bsp_serial_port
   import bsp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire bsp_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic movx_wr_pulse,
   input wire logic timer_zero_expiry_pulse,
   input wire logic timer_one_expiry_pulse,
   input wire logic sw_sck_level,
   input wire bsp_pin_in_t pin_in,
   output bsp_pin_out_t pin_out,
   output logic port_active,
   output logic count_interrupt,
   output logic start_stop_interrupt
);
   bsp_pin_in_t pin_s;
   logic [3:0] sctl_q;
   logic [2:0] tctl_q;
   bsp_clk_src_t csel_q;
   logic pdn_q;
   logic [7:0] sh_q;
   logic dout_q;
   logic [3:0] cnt_q;
   logic cnt_int_q;
   logic ack_phase_q;
   logic stretch_q;
   logic ssi_q;
   logic gen_q;
   logic sck_prev_q;
   logic din_prev_q;
   logic [7:0] rdata_q;
   logic [7:0] rd_val;
   logic active, master, i2c, lsbf, same_edge, ss_block;
   logic eff_sck, rise, fall, start_det, stop_det, bus_cond;
   logic samp_e, launch_e, count_e, wrap, hit;
   logic data_wr, data_rd, data_acc;
   logic [3:0] target, cnt_next;

   // First bit to leave the shifter for the chosen order
   function automatic logic bsp_top(input logic [7:0] v, input logic lsb);
      return lsb ? v[0] : v[7];
   endfunction

   // Pins cross into the clock domain
   bsp_sync #(.WIDTH($bits(bsp_pin_in_t))) u_sync
   (
      .clk(clk),
      .resetn(resetn),
      .d(pin_in),
      .q(pin_s)
   );

   // Register decode
   assign data_wr = sfr_req.wr && (sfr_req.addr == BSP_ADDR_DATA);
   assign data_rd = sfr_req.rd && (sfr_req.addr == BSP_ADDR_DATA);
   assign data_acc = data_wr || data_rd;

   // Mode decode
   assign active = !pdn_q;
   assign master = (csel_q != BSP_CS_EXT);
   assign i2c = tctl_q[BSP_TC_I2C];
   assign lsbf = sctl_q[BSP_SC_LSBF] && !i2c;
   assign same_edge = (sctl_q[BSP_SC_CPOL] == sctl_q[BSP_SC_CPHA]);
   assign ss_block = !master && !i2c && sctl_q[BSP_SC_SSEN] && pin_s.ss_n;

   // Clock edges: own clock in SPI master, line level otherwise
   assign eff_sck = (master && !i2c) ? gen_q : pin_s.sck;
   assign rise = active && eff_sck && !sck_prev_q;
   assign fall = active && !eff_sck && sck_prev_q;

   // Data moving while the clock line stays high
   assign start_det = active && i2c && eff_sck && sck_prev_q && din_prev_q && !pin_s.din;
   assign stop_det = active && i2c && eff_sck && sck_prev_q && !din_prev_q && pin_s.din;
   assign bus_cond = start_det || stop_det;

   // Sample, launch and count edges
   assign samp_e = !ss_block && (i2c ? rise : (same_edge ? rise : fall));
   assign launch_e = !ss_block && (i2c ? fall : (same_edge ? fall : rise));
   assign count_e = i2c ? launch_e : samp_e;

   // Count target: byte, or in two-wire mode one bit for acknowledge or when count length select is set
   assign target = (i2c && (tctl_q[BSP_TC_COUNT_LENGTH_SELECT] || ack_phase_q)) ? BSP_CNT_ONE : BSP_CNT_BYTE;
   assign wrap = count_e && (cnt_q >= target);
   assign cnt_next = wrap ? BSP_CNT_ONE : (cnt_q + BSP_CNT_ONE);
   assign hit = count_e && (cnt_next == target);

   // Generated serial clock for master mode
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gen_q <= 1'b0;
      end
      else
      begin
         case (csel_q)
            BSP_CS_SW: gen_q <= sw_sck_level;
            BSP_CS_WR_PULSE: gen_q <= !movx_wr_pulse;
            BSP_CS_WR_TOG: gen_q <= gen_q ^ movx_wr_pulse;
            BSP_CS_T0_PULSE: gen_q <= timer_zero_expiry_pulse;
            BSP_CS_T0_TOG: gen_q <= gen_q ^ timer_zero_expiry_pulse;
            BSP_CS_T1_PULSE: gen_q <= timer_one_expiry_pulse;
            BSP_CS_T1_TOG: gen_q <= gen_q ^ timer_one_expiry_pulse;
            default: gen_q <= gen_q;
         endcase
      end
   end

   // Previous line levels for edge finding
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sck_prev_q <= 1'b1;
         din_prev_q <= 1'b1;
      end
      else
      begin
         sck_prev_q <= eff_sck;
         din_prev_q <= pin_s.din;
      end
   end

   // Shift register: load on write, shift on sample edge
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sh_q <= 8'h00;
      end
      else if (data_wr)
      begin
         sh_q <= sfr_req.wdata;
      end
      else if (samp_e && lsbf)
      begin
         sh_q <= {pin_s.din, sh_q[7:1]};
      end
      else if (samp_e)
      begin
         sh_q <= {sh_q[6:0], pin_s.din};
      end
   end

   // Outgoing bit: first bit at load, next bit on launch edge
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dout_q <= 1'b1;
      end
      else if (data_wr)
      begin
         dout_q <= bsp_top(sfr_req.wdata, lsbf);
      end
      else if (launch_e)
      begin
         dout_q <= bsp_top(sh_q, lsbf);
      end
   end

   // Bit counter
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= BSP_CNT_ZERO;
      end
      else if (data_wr || (i2c && data_rd) || bus_cond)
      begin
         cnt_q <= BSP_CNT_ZERO;
      end
      else if (count_e)
      begin
         cnt_q <= cnt_next;
      end
   end

   // Count interrupt: set wins over clear
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_int_q <= 1'b0;
      end
      else if (hit)
      begin
         cnt_int_q <= 1'b1;
      end
      else if (data_acc || wrap)
      begin
         cnt_int_q <= 1'b0;
      end
   end

   // Acknowledge phase after a two-wire byte
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ack_phase_q <= 1'b0;
      end
      else if (!i2c || bus_cond)
      begin
         ack_phase_q <= 1'b0;
      end
      else if (hit)
      begin
         ack_phase_q <= (target == BSP_CNT_BYTE);
      end
   end

   // Clock stretch after the eighth bit
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stretch_q <= 1'b0;
      end
      else if (i2c && hit && (target == BSP_CNT_BYTE) && tctl_q[BSP_TC_STRETCH])
      begin
         stretch_q <= 1'b1;
      end
      else if (data_wr || tctl_q[BSP_TC_COUNT_LENGTH_SELECT] || bus_cond || !i2c)
      begin
         stretch_q <= 1'b0;
      end
   end

   // START/STOP flag: write one to clear, detection wins
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ssi_q <= 1'b0;
      end
      else if (bus_cond)
      begin
         ssi_q <= 1'b1;
      end
      else if (sfr_req.wr && (sfr_req.addr == BSP_ADDR_TCTL) && sfr_req.wdata[BSP_TC_SSIF])
      begin
         ssi_q <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sctl_q <= BSP_SC_RST;
         csel_q <= BSP_CS_EXT;
         pdn_q <= BSP_PDN_RST;
      end
      else if (sfr_req.wr)
      begin
         case (sfr_req.addr)
            BSP_ADDR_SCTL: sctl_q <= sfr_req.wdata[$bits(sctl_q)-1:0];
            BSP_ADDR_CSEL: csel_q <= bsp_clk_src_t'(sfr_req.wdata[$bits(bsp_clk_src_t)-1:0]);
            BSP_ADDR_PDN: pdn_q <= sfr_req.wdata[BSP_PD_SPI];
            default: sctl_q <= sctl_q;
         endcase
      end
   end

   // Two-wire control; START clears the stretch bit
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tctl_q <= BSP_TC_RST;
      end
      else
      begin
         if (sfr_req.wr && (sfr_req.addr == BSP_ADDR_TCTL))
         begin
            tctl_q <= sfr_req.wdata[$bits(tctl_q)-1:0];
         end
         if (start_det)
         begin
            tctl_q[BSP_TC_STRETCH] <= 1'b0;
         end
      end
   end

   // Read values, unmapped addresses read zero
   always_comb
   begin
      rd_val = 8'h00;
      case (sfr_req.addr)
         BSP_ADDR_DATA: rd_val = sh_q;
         BSP_ADDR_SCTL:
         begin
            rd_val[$bits(sctl_q)-1:0] = sctl_q;
            rd_val[BSP_SC_CNT_LO +: $bits(cnt_q)] = cnt_q;
         end
         BSP_ADDR_TCTL:
         begin
            rd_val[$bits(tctl_q)-1:0] = tctl_q;
            rd_val[BSP_TC_SSIF] = ssi_q;
         end
         BSP_ADDR_CSEL: rd_val[$bits(bsp_clk_src_t)-1:0] = csel_q;
         BSP_ADDR_PDN: rd_val[BSP_PD_SPI] = pdn_q;
         default: rd_val = 8'h00;
      endcase
   end

   // Read data held one cycle after the strobe
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata_q <= 8'h00;
      end
      else if (sfr_req.rd)
      begin
         rdata_q <= rd_val;
      end
   end

   // Pin drive; two-wire lines are open drain
   assign pin_out.sck_out = i2c ? 1'b0 : gen_q;
   assign pin_out.sck_oe = active && (i2c ? ((master && !gen_q) || stretch_q) : master);
   assign pin_out.dout_out = i2c ? 1'b0 : dout_q;
   assign pin_out.dout_oe = active && (i2c ? !dout_q : (master || !sctl_q[BSP_SC_SSEN] || !pin_s.ss_n));
   assign port_active = active;
   assign count_interrupt = cnt_int_q;
   assign start_stop_interrupt = ssi_q;
   assign sfr_rdata = rdata_q;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_ss_freezes_count:
   assert property (ss_block && !data_wr |=> $stable(cnt_q))
      else $error("counter moved while slave deselected");
   a_slave_dout_hiz:
   assert property (ss_block |-> !pin_out.dout_oe)
      else $error("data-out driven while slave deselected");
   a_count_hits_eight:
   assert property (!i2c && count_e && !data_wr && cnt_next == BSP_CNT_BYTE |=> cnt_int_q && cnt_q == BSP_CNT_BYTE)
      else $error("no count interrupt at eight bits");
   a_access_clears_int:
   assert property (data_acc && !hit |=> !cnt_int_q)
      else $error("data access left count interrupt set");
   a_readback_count:
   assert property (sfr_req.rd && sfr_req.addr == BSP_ADDR_SCTL |=> sfr_rdata[7:4] == $past(cnt_q))
      else $error("control read does not show bit count");
   a_powerdown_idle:
   assert property (pdn_q |-> !pin_out.sck_oe && !pin_out.dout_oe && !port_active)
      else $error("powered-down port drives pins");
   a_new_xfer_drops:
   assert property (!i2c && wrap && !data_wr |=> !cnt_int_q && cnt_q == BSP_CNT_ONE)
      else $error("stale count interrupt survived new transfer");
   a_bus_cond_flag:
   assert property (bus_cond |=> ssi_q ##1 ssi_q || $past(sfr_req.wr))
      else $error("START/STOP not flagged");
   a_i2c_rise_holds:
   assert property (i2c && rise && !data_acc && !bus_cond |=> $stable(cnt_q))
      else $error("two-wire counter moved on rising clock");
   a_stretch_holds_scl:
   assert property (stretch_q && active |-> pin_out.sck_oe && !pin_out.sck_out)
      else $error("clock not held low while stretching");
   a_start_kills_stretch:
   assert property (start_det |=> !tctl_q[BSP_TC_STRETCH])
      else $error("START left stretch control set");

   c_spi_byte: cover property (!i2c && hit);
   c_i2c_start: cover property (start_det);
   c_stretch: cover property (stretch_q && active);
endmodule

// ### hw/bsp_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module bsp_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q <= '1;
         sync_q <= '1;
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule

// ### tb/bsp_serial_port_tb_top.sv
// Self-checking bench for the basic serial port
`timescale 1ns/1ns
module bsp_serial_port_tb_top
   import bsp_pkg::*;
;
   logic clk;
   logic resetn;
   bsp_sfr_req_t sfr_req;
   logic [7:0] sfr_rdata;
   logic timer0;
   bsp_pin_in_t pin_in;
   bsp_pin_out_t pin_out;
   logic port_active;
   logic count_interrupt;
   logic start_stop_interrupt;
   logic m_sck;
   logic m_ss_n;
   logic m_din;
   logic m_oe;
   logic i2c_tie;
   int miscompares;
   int n_compared;
   int cycles;

   // Wired-AND of the open-drain lines in two-wire use
   assign pin_in.ss_n = m_ss_n;
   assign pin_in.din = m_din & !(i2c_tie & pin_out.dout_oe & !pin_out.dout_out);
   assign pin_in.sck = m_sck & !(i2c_tie & pin_out.sck_oe & !pin_out.sck_out);

   bsp_serial_port u_bsp_serial_port
   (
      .clk(clk),
      .resetn(resetn),
      .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata),
      .movx_wr_pulse(1'b0),
      .timer_zero_expiry_pulse(timer0),
      .timer_one_expiry_pulse(1'b0),
      .sw_sck_level(1'b0),
      .pin_in(pin_in),
      .pin_out(pin_out),
      .port_active(port_active),
      .count_interrupt(count_interrupt),
      .start_stop_interrupt(start_stop_interrupt)
   );

   bsp_spi_master_model u_m
   (
      .clk(clk),
      .sck(m_sck),
      .ss_n(m_ss_n),
      .din(m_din),
      .dout(pin_out.dout_out),
      .dout_oe(pin_out.dout_oe),
      .oe_seen(m_oe)
   );

   // System clock, 20 ns
   always #10 clk = !clk;

   // Hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         miscompares = miscompares + 1;
         conclude();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      sfr_req.wr <= 1'b0;
      #1;
   endtask

   task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      sfr_req.rd <= 1'b0;
      #1;
      d = sfr_rdata;
   endtask

   task automatic test_reset();
      logic [7:0] d;
      chk({7'h00, port_active}, 8'h00);
      chk({6'h00, pin_out.dout_oe, pin_out.sck_oe}, 8'h00);
      sfr_rd(BSP_ADDR_PDN, d);
      chk(d, 8'h02);
      sfr_rd(BSP_ADDR_SCTL, d);
      chk(d, 8'h00);
      sfr_rd(8'h55, d);
      chk(d, 8'h00);
      sfr_wr(BSP_ADDR_PDN, 8'h00);
      chk({7'h00, port_active}, 8'h01);
      $display("test reset done");
   endtask

   task automatic test_spi_slave();
      logic [7:0] d;
      logic [7:0] rx;
      sfr_wr(BSP_ADDR_SCTL, 8'h08);
      sfr_wr(BSP_ADDR_DATA, 8'hA5);
      u_m.xfer(8'h3C, 1'b0, 1'b0, 1'b0, 1'b1, rx);
      chk(rx, 8'hA5);
      chk({7'h00, m_oe}, 8'h01);
      chk({7'h00, count_interrupt}, 8'h01);
      sfr_rd(BSP_ADDR_SCTL, d);
      chk(d, 8'h88);
      u_m.xfer(8'hC3, 1'b0, 1'b0, 1'b0, 1'b1, rx);
      sfr_rd(BSP_ADDR_DATA, d);
      chk(d, 8'hC3);
      chk({7'h00, count_interrupt}, 8'h00);
      $display("test spi slave done");
   endtask

   task automatic test_deselect();
      logic [7:0] d;
      logic [7:0] rx;
      sfr_wr(BSP_ADDR_DATA, 8'h5A);
      u_m.xfer(8'hFF, 1'b0, 1'b0, 1'b0, 1'b0, rx);
      chk({7'h00, m_oe}, 8'h00);
      chk({7'h00, count_interrupt}, 8'h00);
      sfr_rd(BSP_ADDR_SCTL, d);
      chk(d, 8'h08);
      $display("test deselect done");
   endtask

   task automatic test_modes();
      logic [7:0] d;
      logic [7:0] rx;
      logic [7:0] k;
      for (int m = 0; m < 8; m++)
      begin
         k = 8'(m);
         sfr_wr(BSP_ADDR_SCTL, {5'h01, k[2:0]});
         sfr_wr(BSP_ADDR_DATA, 8'hC6 ^ k);
         u_m.xfer(8'h4B ^ k, k[1], k[0], k[2], 1'b1, rx);
         chk(rx, 8'hC6 ^ k);
         chk({7'h00, count_interrupt}, 8'h01);
         if (k[0])
            sfr_wr(BSP_ADDR_DATA, 8'h00);
         else
            sfr_rd(BSP_ADDR_DATA, d);
         if (!k[0])
            chk(d, 8'h4B ^ k);
         chk({7'h00, count_interrupt}, 8'h00);
      end
      $display("test modes done");
   endtask

   task automatic test_master_toggle();
      logic [7:0] d;
      logic s0;
      sfr_wr(BSP_ADDR_SCTL, 8'h00);
      sfr_wr(BSP_ADDR_CSEL, 8'h05);
      sfr_rd(BSP_ADDR_CSEL, d);
      chk(d, 8'h05);
      sfr_wr(BSP_ADDR_DATA, 8'h81);
      chk({7'h00, pin_out.sck_oe}, 8'h01);
      s0 = pin_out.sck_out;
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clk);
         timer0 <= 1'b1;
         @(posedge clk);
         timer0 <= 1'b0;
         repeat (6) @(posedge clk);
         #1;
         if (i == 0)
            chk({7'h00, pin_out.sck_out}, {7'h00, !s0});
      end
      chk({7'h00, count_interrupt}, 8'h01);
      sfr_wr(BSP_ADDR_CSEL, 8'h00);
      sfr_rd(BSP_ADDR_DATA, d);
      $display("test master toggle done");
   endtask

   task automatic test_two_wire();
      logic [7:0] d;
      // Data-out must idle high before the lines are tied
      sfr_wr(BSP_ADDR_DATA, 8'hFF);
      i2c_tie = 1'b1;
      sfr_wr(BSP_ADDR_TCTL, 8'h05);
      u_m.start_stop();
      #1;
      chk({7'h00, start_stop_interrupt}, 8'h01);
      sfr_rd(BSP_ADDR_TCTL, d);
      chk(d, 8'h81);
      sfr_wr(BSP_ADDR_TCTL, 8'h80);
      sfr_rd(BSP_ADDR_TCTL, d);
      chk(d, 8'h00);
      // Byte with stretching, then acknowledge bit
      sfr_wr(BSP_ADDR_TCTL, 8'h05);
      sfr_wr(BSP_ADDR_DATA, 8'hFF);
      u_m.pulses(8);
      #1;
      chk({7'h00, count_interrupt}, 8'h01);
      chk({7'h00, pin_out.sck_oe}, 8'h01);
      sfr_wr(BSP_ADDR_DATA, 8'h7F);
      chk({7'h00, pin_out.sck_oe}, 8'h00);
      chk({7'h00, count_interrupt}, 8'h00);
      u_m.pulses(1);
      #1;
      chk({7'h00, count_interrupt}, 8'h01);
      sfr_wr(BSP_ADDR_TCTL, 8'h80);
      $display("test two wire done");
   endtask

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Reset, then the scenarios in turn
   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      sfr_req = '0;
      timer0 = 1'b0;
      i2c_tie = 1'b0;
      miscompares = 0;
      n_compared = 0;
      cycles = 0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      #1;
      test_reset();
      test_spi_slave();
      test_deselect();
      test_modes();
      test_master_toggle();
      test_two_wire();
      conclude();
   end
endmodule

// ### tb/bsp_spi_master_model.sv
// Behavioural far-side device: SPI master and two-wire bus driver
`timescale 1ns/1ns
module bsp_spi_master_model
(
   input wire logic clk,
   output logic sck,
   output logic ss_n,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe,
   output logic oe_seen
);
   // Pins idle; serial clock stands still between frames
   initial
   begin
      sck = 1'b0;
      ss_n = 1'b1;
      din = 1'b1;
      oe_seen = 1'b0;
   end

   // Note any drive of data-out during a frame
   always @(posedge clk)
      if (dout_oe)
         oe_seen <= 1'b1;

   // Wait some system clock edges
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One byte at 240 ns per serial clock; sel low leaves the slave deselected
   task automatic xfer(input logic [7:0] tx, input logic cpol, input logic cpha, input logic lsbf,
                       input logic sel, output logic [7:0] rx);
      int b;
      rx = 8'h00;
      @(posedge clk);
      oe_seen = 1'b0;
      sck <= cpol;
      tick(4);
      ss_n <= !sel;
      for (int i = 0; i < 8; i++)
      begin
         b = lsbf ? i : 7 - i;
         if (!cpha)
            din <= tx[b];
         tick(4);
         sck <= !cpol;
         if (cpha)
            din <= tx[b];
         tick(2);
         if (!cpha)
            rx[b] = dout;
         tick(2);
         sck <= cpol;
         tick(2);
         if (cpha)
            rx[b] = dout;
         tick(2);
      end
      tick(4);
      ss_n <= 1'b1;
      din <= !din;
      tick(4);
   endtask

   // Two-wire clock pulses: rise then fall, line ends low
   task automatic pulses(input int n);
      repeat (n)
      begin
         @(posedge clk);
         sck <= 1'b1;
         tick(4);
         sck <= 1'b0;
         tick(4);
      end
   endtask

   // START then STOP with the clock line high
   task automatic start_stop();
      @(posedge clk);
      sck <= 1'b1;
      din <= 1'b1;
      tick(8);
      din <= 1'b0;
      tick(8);
      din <= 1'b1;
      tick(8);
   endtask
endmodule
